/* rtl/cfg_target.sv */
// Configuration target end: two-wire slave holding the third and fourth
// channel configuration bytes.
// Assumes the link wires and the address-select pins are asynchronous to
// CLK_SYS_I and that the link clock is far slower than the system clock.
//
// Functional notes
// - Each byte is eight bits before acknowledge
// - Bits move most significant first
// - Hold data low through acknowledge high phase
// - Acknowledge every byte received from master
// - Master opens each transfer with start
// - Match address after start, else stay silent
// - Master ends read with no-ack, stop
// - First write byte after address is index
// - Data falling while clock high is start
// - Data rising while clock high is stop
// - Four-bit equalizer code per channel
// - Two-bit flat gain code per channel
// - Two-bit output swing code per channel
`timescale 1ns/1ps
module cfg_target
  import cfg_pkg::*;
(
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      RSTN_I,
  cfg_link_if.target                     LINK,
  input  wire logic [3:0]                ADDR_SEL_I,
  output logic      [EQ_MSB-EQ_LSB:0]    THIRD_EQUALIZER_CODE_O,
  output logic      [FG_MSB-FG_LSB:0]    THIRD_FLAT_GAIN_CODE_O,
  output logic      [SW_MSB-SW_LSB:0]    THIRD_OUTPUT_SWING_CODE_O,
  output logic      [EQ_MSB-EQ_LSB:0]    FOURTH_EQUALIZER_CODE_O,
  output logic      [FG_MSB-FG_LSB:0]    FOURTH_FLAT_GAIN_CODE_O,
  output logic      [SW_MSB-SW_LSB:0]    FOURTH_OUTPUT_SWING_CODE_O
);
  import cfg_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    T_IDLE,
    T_RX,
    T_ACK,
    T_TX,
    T_MACK,
    T_SKIP
  } tgt_st_t;

  typedef struct packed {
    tgt_st_t    st;
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    logic [3:0] sel_m;
    logic [3:0] sel_s;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] idx;
    phase_t     ph;
    logic       rw;
    logic       more;
    logic       oe;
    logic [7:0] third_channel;
    logic [7:0] fourth_channel;
  } tgt_state_t;

  tgt_state_t r;
  tgt_state_t next_r;

  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;
  logic addr_match;
  logic [7:0] rd_here;
  logic [7:0] rd_after;

  // ==========================================================
  // Read mux over the configuration bytes
  function automatic logic [7:0] read_byte(input logic [7:0] i,
                                           input logic [7:0] c3,
                                           input logic [7:0] c4);
    return (i == THIRD_CHANNEL_IDX) ? c3 : (i == FOURTH_CHANNEL_IDX) ? c4 : UNMAPPED_READ;
  endfunction : read_byte
  assign rd_here  = read_byte(r.idx, r.third_channel, r.fourth_channel);
  assign rd_after = read_byte(r.idx + 8'h01, r.third_channel, r.fourth_channel);

  // ==========================================================
  // Edge and condition detection on synchronised wires
  assign rise       = r.scl_s & ~r.scl_p;
  assign fall       = ~r.scl_s & r.scl_p;
  assign start_seen = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
  assign stop_seen  = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
  assign addr_match = (r.sh[7:1] == {ADDR_UPPER, r.sel_s});

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_r       = r;
    // Two-flop synchronisers, then one more stage for edges
    next_r.scl_m = LINK.scl;
    next_r.scl_s = r.scl_m;
    next_r.scl_p = r.scl_s;
    next_r.sda_m = LINK.sda;
    next_r.sda_s = r.sda_m;
    next_r.sda_p = r.sda_s;
    next_r.sel_m = ADDR_SEL_I;
    next_r.sel_s = r.sel_m;

    if (start_seen)
    begin
      // Start or repeated start restarts address matching
      next_r.st  = T_RX;
      next_r.cnt = 4'h0;
      next_r.ph  = PH_ADDR;
      next_r.oe  = 1'b0;
    end
    else if (stop_seen)
    begin
      next_r.st = T_IDLE;
      next_r.oe = 1'b0;
    end
    else
    begin
      case (r.st)
        T_RX:
        begin
          if (rise && (r.cnt < BYTE_BITS))
          begin
            next_r.sh  = {r.sh[6:0], r.sda_s};
            next_r.cnt = r.cnt + 4'h1;
          end
          if (fall && (r.cnt == BYTE_BITS))
          begin
            case (r.ph)
              PH_ADDR:
              begin
                if (addr_match)
                begin
                  next_r.rw = r.sh[0];
                  next_r.st = T_ACK;
                  next_r.oe = 1'b1;
                end
                else
                begin
                  next_r.st = T_SKIP;
                end
              end
              PH_INDEX:
              begin
                next_r.idx = r.sh;
                next_r.st  = T_ACK;
                next_r.oe  = 1'b1;
              end
              default:
              begin
                if (r.idx == THIRD_CHANNEL_IDX)  next_r.third_channel  = r.sh;
                if (r.idx == FOURTH_CHANNEL_IDX) next_r.fourth_channel = r.sh;
                next_r.idx = r.idx + 8'h01;
                next_r.st  = T_ACK;
                next_r.oe  = 1'b1;
              end
            endcase
          end
        end
        T_ACK:
        begin
          // Low held from before the rise until after the fall
          if (fall)
          begin
            next_r.oe  = 1'b0;
            next_r.cnt = 4'h0;
            if ((r.ph == PH_ADDR) && (r.rw == DIR_READ))
            begin
              next_r.st = T_TX;
              next_r.sh = rd_here;
              next_r.oe = ~rd_here[7];
            end
            else
            begin
              next_r.st = T_RX;
              next_r.ph = (r.ph == PH_ADDR) ? PH_INDEX : PH_DATA;
            end
          end
        end
        T_TX:
        begin
          // Bits change only while the clock is low
          if (fall)
          begin
            if (r.cnt == LAST_BIT)
            begin
              next_r.oe = 1'b0;
              next_r.st = T_MACK;
            end
            else
            begin
              next_r.sh  = {r.sh[6:0], 1'b0};
              next_r.oe  = ~r.sh[6];
              next_r.cnt = r.cnt + 4'h1;
            end
          end
        end
        T_MACK:
        begin
          // Master acknowledge asks for another byte; none means done
          if (rise)
          begin
            next_r.more = ~r.sda_s;
          end
          if (fall)
          begin
            if (r.more)
            begin
              next_r.idx = r.idx + 8'h01;
              next_r.sh  = rd_after;
              next_r.oe  = ~rd_after[7];
              next_r.cnt = 4'h0;
              next_r.st  = T_TX;
            end
            else
            begin
              next_r.st = T_SKIP;
            end
          end
        end
        T_IDLE, T_SKIP:
        begin
          next_r.oe = 1'b0;
        end
        default:
        begin
          next_r.st = T_IDLE;
          next_r.oe = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      r                <= '0;
      r.third_channel  <= CFG_RESET;
      r.fourth_channel <= CFG_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign LINK.sda_t_o  = 1'b0;
  assign LINK.sda_t_oe = r.oe;
  assign THIRD_EQUALIZER_CODE_O     = r.third_channel[EQ_MSB:EQ_LSB];
  assign THIRD_FLAT_GAIN_CODE_O     = r.third_channel[FG_MSB:FG_LSB];
  assign THIRD_OUTPUT_SWING_CODE_O  = r.third_channel[SW_MSB:SW_LSB];
  assign FOURTH_EQUALIZER_CODE_O    = r.fourth_channel[EQ_MSB:EQ_LSB];
  assign FOURTH_FLAT_GAIN_CODE_O    = r.fourth_channel[FG_MSB:FG_LSB];
  assign FOURTH_OUTPUT_SWING_CODE_O = r.fourth_channel[SW_MSB:SW_LSB];

endmodule : cfg_target

/* rtl/cfg_pkg.sv */
// Shared constants for the two-wire channel configuration link.
// Assumes both ends run on one 100 MHz system clock.
package cfg_pkg;

  // ==========================================================
  // Clocking and link timing
  localparam int CLK_MHZ       = 100;       // System clock rate
  localparam int SCL_PERIOD_NS = 10000;     // Shortest link clock period (100 kHz)
  localparam int QUARTER_NS    = SCL_PERIOD_NS / 4;
  localparam int QUARTER_CYC   = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  localparam int DIV_W         = 8;         // Width of the quarter-period counter

  // ==========================================================
  // Addressing
  localparam logic [2:0] ADDR_UPPER = 3'h7; // Fixed upper address bits
  localparam logic       DIR_READ   = 1'b1; // Direction bit value for a read
  localparam logic       DIR_WRITE  = 1'b0;

  // ==========================================================
  // Configuration byte indexes and reset value
  localparam logic [7:0] THIRD_CHANNEL_IDX  = 8'h05;
  localparam logic [7:0] FOURTH_CHANNEL_IDX = 8'h06;
  localparam logic [7:0] CFG_RESET          = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ==========================================================
  // Field positions inside a configuration byte
  localparam int EQ_MSB = 7;
  localparam int EQ_LSB = 4;
  localparam int FG_MSB = 3;
  localparam int FG_LSB = 2;
  localparam int SW_MSB = 1;
  localparam int SW_LSB = 0;

  // ==========================================================
  // Byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;  // Bits per byte before the acknowledge
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // Byte position within a target transfer
  typedef enum logic [1:0] {
    PH_ADDR,
    PH_INDEX,
    PH_DATA
  } phase_t;

endpackage : cfg_pkg

/* rtl/cfg_link_if.sv */
// Two-wire link between the bus master end and the configuration target end.
// Assumes open-drain wires with pull-ups; levels are resolved from the enables.
`timescale 1ns/1ps
interface cfg_link_if;
  logic scl;       // Resolved clock wire level
  logic sda;       // Resolved data wire level
  logic scl_m_o;   // Master clock drive value
  logic scl_m_oe;  // Master clock drive enable
  logic sda_m_o;   // Master data drive value
  logic sda_m_oe;  // Master data drive enable
  logic sda_t_o;   // Target data drive value
  logic sda_t_oe;  // Target data drive enable

  // Wired-AND with pull-up
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_t_oe & ~sda_t_o));

  modport master (input scl, input sda, output scl_m_o, output scl_m_oe,
                  output sda_m_o, output sda_m_oe);
  modport target (input scl, input sda, output sda_t_o, output sda_t_oe);
endinterface : cfg_link_if

/* rtl/cfg_master.sv */
// Bus master end: turns one command into a complete two-wire transfer.
// Assumes commands come from logic on CLK_SYS_I; the data wire is asynchronous.
`timescale 1ns/1ps
module cfg_master
  import cfg_pkg::*;
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       RSTN_I,
  cfg_link_if.master      LINK,
  input  wire logic       CMD_VALID_I,
  input  wire logic       CMD_READ_I,
  input  wire logic [3:0] CMD_ADDR_SEL_I,
  input  wire logic [7:0] CMD_INDEX_I,
  input  wire logic [7:0] CMD_DATA_I,
  output logic            CMD_READY_O,
  output logic            RSP_VALID_O,
  output logic      [7:0] RSP_DATA_O,
  output logic            RSP_NACK_O
);
  import cfg_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_RSTART,
    M_STOP
  } mst_st_t;

  typedef struct packed {
    mst_st_t          st;
    logic [DIV_W-1:0] div;
    logic [1:0]       q;
    logic [3:0]       bitn;
    logic [2:0]       bno;
    logic             rd;
    logic [3:0]       asel;
    logic [7:0]       idx;
    logic [7:0]       dat;
    logic [7:0]       sh;
    logic [7:0]       rx;
    logic             nack;
    logic             scl_oe;
    logic             sda_oe;
    logic             rsp_v;
    logic             sda_m;
    logic             sda_s;
  } mst_state_t;

  mst_state_t r;
  mst_state_t next_r;
  logic       tick;
  logic       rx_byte;

  assign tick    = (r.div == DIV_W'(QUARTER_CYC - 1));
  assign rx_byte = (r.bno == 3'h4);

  // ==========================================================
  // Next-state logic: four quarters per link clock bit
  always_comb
  begin
    next_r       = r;
    next_r.sda_m = LINK.sda;
    next_r.sda_s = r.sda_m;
    next_r.rsp_v = 1'b0;
    if (r.st != M_IDLE)
    begin
      next_r.div = tick ? '0 : r.div + 1'b1;
      if (tick)
      begin
        next_r.q = r.q + 2'h1;
      end
    end
    case (r.st)
      M_IDLE:
      begin
        if (CMD_VALID_I)
        begin
          next_r.st   = M_START;
          next_r.div  = '0;
          next_r.q    = 2'h0;
          next_r.bno  = 3'h0;
          next_r.nack = 1'b0;
          next_r.rd   = CMD_READ_I;
          next_r.asel = CMD_ADDR_SEL_I;
          next_r.idx  = CMD_INDEX_I;
          next_r.dat  = CMD_DATA_I;
        end
      end
      M_START:
      begin
        // Data falls while clock is high, then clock falls
        if (tick)
        begin
          case (r.q)
            2'h0: next_r.sda_oe = 1'b0;
            2'h1: next_r.sda_oe = 1'b1;
            2'h2: next_r.scl_oe = 1'b1;
            default:
            begin
              next_r.st   = M_BIT;
              next_r.bitn = 4'h0;
              next_r.sh   = {ADDR_UPPER, r.asel, DIR_WRITE};
            end
          endcase
        end
      end
      M_BIT:
      begin
        if (tick)
        begin
          case (r.q)
            2'h0: next_r.sda_oe = (r.bitn < BYTE_BITS) & ~rx_byte & ~r.sh[7];
            2'h1: next_r.scl_oe = 1'b0;
            2'h2:
            begin
              if (r.bitn < BYTE_BITS)
              begin
                next_r.rx = {r.rx[6:0], r.sda_s};
              end
              else if (!rx_byte)
              begin
                next_r.nack = r.sda_s;
              end
            end
            default:
            begin
              next_r.scl_oe = 1'b1;
              next_r.bitn   = r.bitn + 4'h1;
              next_r.sh     = {r.sh[6:0], 1'b0};
              if (r.bitn == BYTE_BITS)
              begin
                next_r.bitn = 4'h0;
                if (r.nack && !rx_byte)
                begin
                  next_r.st = M_STOP;
                end
                else
                begin
                  case (r.bno)
                    3'h0:
                    begin
                      next_r.bno = 3'h1;
                      next_r.sh  = r.idx;
                    end
                    3'h1:
                    begin
                      next_r.bno = 3'h2;
                      next_r.sh  = r.dat;
                      if (r.rd)
                      begin
                        next_r.st = M_RSTART;
                      end
                    end
                    3'h3: next_r.bno = 3'h4;
                    default: next_r.st = M_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
      M_RSTART:
      begin
        // Repeated start, then the address with the read direction
        if (tick)
        begin
          case (r.q)
            2'h0: next_r.sda_oe = 1'b0;
            2'h1: next_r.scl_oe = 1'b0;
            2'h2: next_r.sda_oe = 1'b1;
            default:
            begin
              next_r.scl_oe = 1'b1;
              next_r.st     = M_BIT;
              next_r.bno    = 3'h3;
              next_r.sh     = {ADDR_UPPER, r.asel, DIR_READ};
            end
          endcase
        end
      end
      M_STOP:
      begin
        // Data rises while clock is high
        if (tick)
        begin
          case (r.q)
            2'h0: next_r.sda_oe = 1'b1;
            2'h1: next_r.scl_oe = 1'b0;
            2'h2: next_r.sda_oe = 1'b0;
            default:
            begin
              next_r.st    = M_IDLE;
              next_r.rsp_v = 1'b1;
            end
          endcase
        end
      end
      default: next_r.st = M_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign CMD_READY_O   = (r.st == M_IDLE);
  assign RSP_VALID_O   = r.rsp_v;
  assign RSP_DATA_O    = r.rx;
  assign RSP_NACK_O    = r.nack;
  assign LINK.scl_m_o  = 1'b0;
  assign LINK.scl_m_oe = r.scl_oe;
  assign LINK.sda_m_o  = 1'b0;
  assign LINK.sda_m_oe = r.sda_oe;

endmodule : cfg_master

/* testbench/cfg_link_chk.sv */
// Concurrent checks on the two-wire link between master and target.
// Assumes one system clock; sees only the link wires, enables and the target drive value.
`timescale 1ns/1ps
module cfg_link_chk #(
  parameter logic [6:0] ADDR7 = 7'h7A
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_t_o,
  input wire logic sda_t_oe
);
  // ==========================================================
  // Helper state: wire history, bit count and transfer role
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       first;
  logic       mine;
  logic       rd;
  logic       mute;
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire stop_ev  = scl && scl_q && !sda_q && sda;
  wire rise     = scl && !scl_q;

  // Count clock rises per byte, capture bytes, note address match
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt   <= 4'h0;
      sh    <= 8'h00;
      first <= 1'b0;
      mine  <= 1'b0;
      rd    <= 1'b0;
      mute  <= 1'b0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev || stop_ev)
      begin
        cnt   <= 4'h0;
        first <= start_ev;
        mine  <= 1'b0;
        rd    <= 1'b0;
        mute  <= 1'b0;
      end
      else if (rise)
      begin
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        if (cnt < 4'h8)
          sh <= {sh[6:0], sda};
        if (cnt == 4'h8 && first)
        begin
          first <= 1'b0;
          mine  <= (sh[7:1] == ADDR7);
          rd    <= sh[0];
          mute  <= (sh[7:1] != ADDR7);
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  chk_addr_ack_low: assert property (
    rise && first && cnt == 4'h8 && sh[7:1] == ADDR7 |-> sda_t_oe && !sda)
    else $error("matching address byte not acknowledged");
  chk_write_byte_ack: assert property (
    rise && mine && !rd && cnt == 4'h8 |-> sda_t_oe && !sda)
    else $error("written byte not acknowledged");
  chk_mismatch_silent: assert property (mute |-> !sda_t_oe)
    else $error("target drives after address mismatch");
  chk_drive_on_low: assert property ($rose(sda_t_oe) |-> !scl)
    else $error("target takes data line while clock high");
  chk_release_on_low: assert property ($fell(sda_t_oe) |-> !scl)
    else $error("target lets go of data line while clock high");
  chk_addr_shift_quiet: assert property (first && cnt < 4'h8 |-> !sda_t_oe)
    else $error("target drives during address byte");
  chk_ack_after_eight: assert property (
    $rose(sda_t_oe) && !(mine && rd) |-> cnt == 4'h8)
    else $error("acknowledge not after eighth bit");
  chk_read_last_noack: assert property (
    rise && mine && rd && cnt == 4'h8 |-> sda && !sda_t_oe && !sda_m_oe)
    else $error("last read byte acknowledged");
  chk_start_clock_hold: assert property (start_ev |=> scl [*8])
    else $error("clock not held high after start");
  chk_open_drain_zero: assert property (sda_t_oe |-> !sda_t_o)
    else $error("target drives data line high");

  // Main scenarios reached
  cover property (rise && first && cnt == 4'h8 && sda_t_oe);
  cover property (rise && mine && rd && cnt == 4'h8);
  cover property (mute);
endmodule : cfg_link_chk

/* testbench/i2c_channel_config_test.sv */
// Self-checking bench: master end and target end joined by the link.
// Assumes cfg_pkg, the link interface and both ends are compiled first.
`timescale 1ns/1ps
module i2c_channel_config_test;
  import cfg_pkg::*;
  localparam logic [3:0] SEL = 4'hA;
  logic       clk_sys;
  logic       rstn      = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_read  = 1'b0;
  logic [3:0] cmd_sel   = 4'h0;
  logic [7:0] cmd_index = 8'h00;
  logic [7:0] cmd_data  = 8'h00;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic [3:0] eq3;
  logic [3:0] eq4;
  logic [1:0] fg3;
  logic [1:0] fg4;
  logic [1:0] sw3;
  logic [1:0] sw4;
  logic [7:0] wire_bytes[$];
  logic [7:0] cur       = 8'h00;
  int         bitn      = 0;
  int         errors    = 0;
  int         checks    = 0;

  cfg_link_if lnk ();

  // ==========================================================
  // Both ends and the link checker
  cfg_target u_cfg_target (
    .CLK_SYS_I                 (clk_sys),
    .RSTN_I                    (rstn),
    .LINK                      (lnk),
    .ADDR_SEL_I                (SEL),
    .THIRD_EQUALIZER_CODE_O    (eq3),
    .THIRD_FLAT_GAIN_CODE_O    (fg3),
    .THIRD_OUTPUT_SWING_CODE_O (sw3),
    .FOURTH_EQUALIZER_CODE_O   (eq4),
    .FOURTH_FLAT_GAIN_CODE_O   (fg4),
    .FOURTH_OUTPUT_SWING_CODE_O(sw4)
  );
  cfg_master u_cfg_master (
    .CLK_SYS_I     (clk_sys),
    .RSTN_I        (rstn),
    .LINK          (lnk),
    .CMD_VALID_I   (cmd_valid),
    .CMD_READ_I    (cmd_read),
    .CMD_ADDR_SEL_I(cmd_sel),
    .CMD_INDEX_I   (cmd_index),
    .CMD_DATA_I    (cmd_data),
    .CMD_READY_O   (cmd_ready),
    .RSP_VALID_O   (rsp_valid),
    .RSP_DATA_O    (rsp_data),
    .RSP_NACK_O    (rsp_nack)
  );
  cfg_link_chk #(.ADDR7({ADDR_UPPER, SEL})) u_cfg_link_chk (
    .CLK_SYS_I(clk_sys),
    .RSTN_I   (rstn),
    .scl      (lnk.scl),
    .sda      (lnk.sda),
    .sda_m_oe (lnk.sda_m_oe),
    .sda_t_o  (lnk.sda_t_o),
    .sda_t_oe (lnk.sda_t_oe)
  );

  // System clock, 10 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Wire monitor: bytes on the data line, count restarted at each start
  always @(negedge lnk.sda)
    if (lnk.scl === 1'b1)
      bitn = 0;
  always @(posedge lnk.scl)
  begin
    cur = {cur[6:0], lnk.sda};
    bitn = bitn + 1;
    if (bitn == 8)
      wire_bytes.push_back(cur);
    if (bitn == 9)
      bitn = 0;
  end

  // ==========================================================
  // Shared tasks
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : cmp_flag

  // One command offered in idle, then wait for its response pulse
  task automatic run_cmd(input logic rd, input logic [3:0] sel, input logic [7:0] idx,
                         input logic [7:0] dat);
    int n;
    wire_bytes.delete();
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_sel   = sel;
    cmd_index = idx;
    cmd_data  = dat;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (n = 0; n < 60000 && rsp_valid !== 1'b1; n++)
      @(negedge clk_sys);
    cmp_flag(rsp_valid, 1'b1, "response pulse");
  endtask : run_cmd

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    cmp_byte({eq3, fg3, sw3}, CFG_RESET, "third after reset");
    cmp_byte({eq4, fg4, sw4}, CFG_RESET, "fourth after reset");
    cmp_flag(lnk.scl & lnk.sda, 1'b1, "idle wires");
    cmp_flag(cmd_ready, 1'b1, "ready in idle");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_write;
    run_cmd(DIR_WRITE, SEL, FOURTH_CHANNEL_IDX, 8'hB6);
    cmp_flag(rsp_nack, 1'b0, "write acknowledged");
    cmp_byte(wire_bytes[0], {ADDR_UPPER, SEL, DIR_WRITE}, "address byte");
    cmp_byte(wire_bytes[1], FOURTH_CHANNEL_IDX, "index byte");
    cmp_byte(wire_bytes[2], 8'hB6, "data byte");
    cmp_byte({4'h0, eq4}, 8'h0B, "equalizer code");
    cmp_byte({6'h00, fg4}, 8'h01, "flat gain code");
    cmp_byte({6'h00, sw4}, 8'h02, "swing code");
    cmp_byte({eq3, fg3, sw3}, CFG_RESET, "third untouched");
    $display("test_write done");
  endtask : test_write

  task automatic test_read;
    run_cmd(DIR_READ, SEL, FOURTH_CHANNEL_IDX, 8'h00);
    cmp_flag(rsp_nack, 1'b0, "read acknowledged");
    cmp_byte(rsp_data, 8'hB6, "read data");
    cmp_byte(wire_bytes[2], {ADDR_UPPER, SEL, DIR_READ}, "read address");
    cmp_byte(wire_bytes[3], 8'hB6, "read byte on wire");
    cmp_byte(8'(wire_bytes.size()), 8'h04, "bytes in read");
    $display("test_read done");
  endtask : test_read

  task automatic test_wrong_addr;
    run_cmd(DIR_WRITE, SEL ^ 4'h5, THIRD_CHANNEL_IDX, 8'hFF);
    cmp_flag(rsp_nack, 1'b1, "foreign address refused");
    cmp_byte(8'(wire_bytes.size()), 8'h01, "bytes before stop");
    cmp_byte({eq3, fg3, sw3}, CFG_RESET, "third unchanged");
    $display("test_wrong_addr done");
  endtask : test_wrong_addr

  // Main sequence
  initial
  begin
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    test_reset();
    test_write();
    test_read();
    test_wrong_addr();
    report_and_stop();
  end

  // Watchdog: the scenarios need about 80000 cycles
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : i2c_channel_config_test
